//--- rtl/esc_pkg.sv
// Constants and types shared by the serial EEPROM command core
package esc_pkg;

	// ****************************************************************
	// Array geometry
	// ****************************************************************
	localparam int              ADDR_W     = 10;
	localparam int              MEM_BYTES  = 1024;
	localparam int              PAGE_A     = 16;
	localparam int              PAGE_B     = 32;
	localparam logic [9:0]      ADDR_LAST  = 10'h3ff;
	localparam logic [9:0]      ADDR_ZERO  = 10'h000;
	localparam logic [9:0]      ADDR_ONE   = 10'h001;
	localparam logic [9:0]      QUARTER_BASE = 10'h300;
	localparam logic [9:0]      HALF_BASE  = 10'h200;

	// ****************************************************************
	// Instruction bytes and bit counting
	// ****************************************************************
	localparam logic [7:0]      OP_ARRAY_READ   = 8'h03;
	localparam logic [7:0]      OP_ARRAY_WRITE  = 8'h02;
	localparam logic [7:0]      OP_CLEAR_LATCH  = 8'h04;
	localparam logic [7:0]      OP_SET_LATCH    = 8'h06;
	localparam logic [7:0]      OP_STATUS_READ  = 8'h05;
	localparam logic [7:0]      OP_STATUS_WRITE = 8'h01;
	localparam logic [3:0]      BYTE_LAST  = 4'h7;
	localparam logic [3:0]      ADDR_LAST_BIT = 4'hf;

	// ****************************************************************
	// Status word layout
	// ****************************************************************
	localparam int              SR_BUSY     = 0;
	localparam int              SR_LATCH    = 1;
	localparam int              SR_GUARD_LO = 2;
	localparam int              SR_GUARD_HI = 3;
	localparam int              SR_PIN_EN   = 7;
	localparam logic [2:0]      SR_RSVD     = 3'h0;
	localparam logic [1:0]      GUARD_NONE    = 2'h0;
	localparam logic [1:0]      GUARD_QUARTER = 2'h1;
	localparam logic [1:0]      GUARD_HALF    = 2'h2;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int              WRITE_TIME_MS    = 5;
	localparam int              MCLK_KHZ         = 20000;
	localparam int              WRITE_CYCLES_DEF = WRITE_TIME_MS * MCLK_KHZ;

	typedef enum logic [7:0] {
		ST_CMD    = 8'h01,
		ST_ADDR   = 8'h02,
		ST_WDATA  = 8'h04,
		ST_RDATA  = 8'h08,
		ST_SRDATA = 8'h10,
		ST_SWDATA = 8'h20,
		ST_END    = 8'h40,
		ST_DEAD   = 8'h80
	} esc_phase_t;

	typedef enum logic [4:0] {
		CM_NONE = 5'h01,
		CM_SET  = 5'h02,
		CM_CLR  = 5'h04,
		CM_SWR  = 5'h08,
		CM_AWR  = 5'h10
	} esc_commit_t;

endpackage

//--- rtl/esc_sync.sv
// Two-flop synchroniser for a group of slow or quasi-static bits
`timescale 1ns/1ps
`default_nettype none
module esc_sync #(
	parameter int WIDTH = 1
)(
	input  wire logic             clk, // Destination clock
	input  wire logic [WIDTH-1:0] d,   // Bits from the other domain
	output logic      [WIDTH-1:0] q    // Synchronised bits
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} esc_sync_t;

	esc_sync_t r;
	esc_sync_t next_r;

	if (WIDTH < 1)
	begin : g_bad_width
		$error("esc_sync: WIDTH must be at least 1");
	end

	always_comb
	begin
		next_r.meta   = d;
		next_r.stable = r.meta;
	end

	always_ff @(posedge clk)
	begin
		r <= next_r;
	end

	assign q = r.stable;
endmodule // esc_sync
`default_nettype wire

//--- rtl/esc_wtimer.sv
// Self-timed write cycle counter
`timescale 1ns/1ps
`default_nettype none
module esc_wtimer
	import esc_pkg::*;
#(
	parameter int CYCLES = WRITE_CYCLES_DEF
)(
	input  wire logic clk,   // System clock
	input  wire logic rst_n, // Synchronous reset, active low
	input  wire logic start, // One-cycle pulse, ignored while busy
	output logic      busy,  // High while the cycle runs
	output logic      done   // One-cycle pulse at the end
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          busy;
		logic          done;
	} esc_timer_t;

	esc_timer_t r;
	esc_timer_t next_r;

	if (CYCLES < 16)
	begin : g_bad_cycles
		$error("esc_wtimer: CYCLES must be at least 16");
	end

	always_comb
	begin
		next_r      = r;
		next_r.done = 1'b0;
		if (r.busy)
		begin
			if (r.cnt == '0)
			begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end
			else
				next_r.cnt = r.cnt - CW'(1);
		end
		else if (start)
		begin
			next_r.busy = 1'b1;
			next_r.cnt  = LOAD;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			r <= '0;
		else
			r <= next_r;
	end

	assign busy = r.busy;
	assign done = r.done;
endmodule // esc_wtimer
`default_nettype wire

//--- rtl/esc_core.sv
// Serial EEPROM command core: serial link, protection, array and write cycle
// What this block does
// R1: Eight-bit instruction shifted in on rising clock
// R2: Host holds select low, pause high
// R3: Everything shifted most significant bit first
// R4: First bit on first rising edge after select
// R5: Pause resumes at the same bit
// R6: Sixteen address bits, top six ignored
// R7: Read streams bytes, address wraps to zero
// R8: Read ends at select rise, output released
// R9: Latch set only after exactly eight bits
// R10: Page of sixteen or thirty-two bytes
// R11: Page write wraps inside its page
// R12: Write starts only on whole-byte boundary
// R13: Array reads refused during write cycle
// R14: Latch cleared when write cycle ends
// R15: Decode array read and write opcodes
// R16: Decode latch set and clear opcodes
// R17: Latch cleared on reset and successes
// R18: Status readable any time
// R19: Busy flag mirrors write cycle, read-only
// R20: Latch commands ignore protection state
// R21: Status write sets block guard ranges
// R22: Protect pin plus enable lock status
// R23: Output changes on falling edge, released deselected
// R24: Pause releases output immediately
// R25: Cleared latch refuses every write
// R26: Guarded bytes dropped, sequence still completes
`timescale 1ns/1ps
`default_nettype none
module esc_core
	import esc_pkg::*;
#(
	parameter int PAGE_BYTES   = PAGE_A,
	parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
)(
	input  wire logic mclk,   // System clock, 20 MHz
	input  wire logic rst_n,  // Synchronous reset, active low
	input  wire logic sck,    // Serial clock from host
	input  wire logic cs_n,   // Chip select, active low
	input  wire logic si,     // Serial data in
	input  wire logic hold_n, // Pause input, active low
	input  wire logic wp_n,   // Write-protect pin, active low
	output logic      so,     // Serial data out
	output logic      so_oe_n // Enable for so, low while driving
);
	localparam int PW = $clog2(PAGE_BYTES);

	if (PAGE_BYTES != PAGE_A && PAGE_BYTES != PAGE_B)
	begin : g_bad_page
		$error("esc_core: PAGE_BYTES must be 16 or 32");
	end

	// ****************************************************************
	// State types
	// ****************************************************************
	typedef struct packed {
		esc_phase_t                 phase;
		logic [3:0]                 cnt;
		logic [7:0]                 shreg;
		logic [7:0]                 opcode;
		logic [ADDR_W-1:0]          addr;
		logic [PW-1:0]              slot;
		logic [PAGE_BYTES-1:0][7:0] pbuf;
		logic [PAGE_BYTES-1:0]      mask;
		logic [7:0]                 sdata;
		esc_commit_t                commit;
	} esc_link_t;

	typedef struct packed {
		logic bit_q;
		logic oe_n;
	} esc_out_t;

	typedef struct packed {
		logic       cs_prev;
		logic       latch;
		logic [1:0] guard;
		logic       pin_en;
		logic       start;
		logic       wr_go;
		logic [7:0] status;
	} esc_ctl_t;

	localparam esc_out_t OUT_IDLE = '{bit_q: 1'b0, oe_n: 1'b1};
	localparam esc_ctl_t CTL_RESET = '{cs_prev: 1'b1, latch: 1'b0, guard: GUARD_NONE,
		pin_en: 1'b0, start: 1'b0, wr_go: 1'b0, status: 8'h00};

	esc_link_t                lr;
	esc_link_t                next_lr;
	esc_link_t                cur;
	esc_out_t                 ro;
	esc_out_t                 next_o;
	esc_ctl_t                 cr;
	esc_ctl_t                 next_cr;
	logic                     fresh;
	logic [7:0]               sh;
	logic [ADDR_W-1:0]        na;
	logic [7:0]               status_sck;
	logic [7:0]               rd_byte;
	logic                     cs_s;
	logic                     wp_s;
	logic [4:0]               code_s;
	logic                     cs_rise;
	logic                     t_busy;
	logic                     t_done;
	logic [ADDR_W-PW-1:0]     page_base;
	logic [7:0]               mem [MEM_BYTES];

	function automatic logic guarded(input logic [ADDR_W-1:0] a, input logic [1:0] g);
		case (g)
			GUARD_NONE:    guarded = 1'b0;
			GUARD_QUARTER: guarded = (a >= QUARTER_BASE);
			GUARD_HALF:    guarded = (a >= HALF_BASE);
			default:       guarded = 1'b1;
		endcase
	endfunction

	// ****************************************************************
	// Link side, rising edge: command, address and data capture
	// ****************************************************************
	// Marks the first edge of a frame; select high forces it, no edge needed
	always_ff @(posedge sck or posedge cs_n)
	begin
		if (cs_n)
			fresh <= 1'b1;
		else
			fresh <= fresh && !hold_n; // R4
	end

	always_comb
	begin
		cur = lr;
		if (fresh)
		begin
			cur.phase  = ST_CMD; // R4
			cur.cnt    = 4'h0;
			cur.mask   = '0;
			cur.commit = CM_NONE;
		end
		sh = {cur.shreg[6:0], si}; // R1 R3
		na = {cur.addr[ADDR_W-2:0], si}; // R6
		next_lr        = cur;
		next_lr.shreg  = sh;
		next_lr.cnt    = cur.cnt + 4'h1;
		case (cur.phase)
			ST_CMD:
			begin
				if (cur.cnt == BYTE_LAST)
				begin
					next_lr.opcode = sh;
					next_lr.cnt    = 4'h0;
					case (sh)
						OP_ARRAY_READ, OP_ARRAY_WRITE: next_lr.phase = ST_ADDR; // R15
						OP_STATUS_READ:  next_lr.phase = ST_SRDATA; // R18
						OP_STATUS_WRITE: next_lr.phase = ST_SWDATA; // R21
						OP_SET_LATCH:
						begin
							next_lr.phase  = ST_END;
							next_lr.commit = CM_SET; // R16
						end
						OP_CLEAR_LATCH:
						begin
							next_lr.phase  = ST_END;
							next_lr.commit = CM_CLR; // R16
						end
						default: next_lr.phase = ST_DEAD;
					endcase
				end
			end
			ST_ADDR:
			begin
				next_lr.addr = na; // R6
				if (cur.cnt == ADDR_LAST_BIT)
				begin
					next_lr.cnt   = 4'h0;
					next_lr.slot  = na[PW-1:0];
					next_lr.phase = (cur.opcode == OP_ARRAY_READ) ? ST_RDATA : ST_WDATA;
				end
			end
			ST_RDATA:
			begin
				if (cur.cnt == BYTE_LAST)
				begin
					next_lr.cnt  = 4'h0;
					next_lr.addr = cur.addr + ADDR_ONE; // R7
				end
			end
			ST_SRDATA:
			begin
				if (cur.cnt == BYTE_LAST)
					next_lr.cnt = 4'h0; // R18
			end
			ST_WDATA:
			begin
				next_lr.commit = CM_NONE; // R12
				if (cur.cnt == BYTE_LAST)
				begin
					next_lr.cnt             = 4'h0;
					next_lr.pbuf[cur.slot]  = sh;
					next_lr.mask[cur.slot]  = 1'b1;
					next_lr.slot            = cur.slot + PW'(1); // R10 R11
					next_lr.commit          = CM_AWR; // R12
				end
			end
			ST_SWDATA:
			begin
				if (cur.cnt == BYTE_LAST)
				begin
					next_lr.sdata  = sh;
					next_lr.phase  = ST_END;
					next_lr.commit = CM_SWR;
				end
			end
			ST_END:
			begin
				// An extra bit (ninth for a latch command, seventeenth for a status write) spoils the command
				next_lr.phase  = ST_DEAD; // R9
				next_lr.commit = CM_NONE;
			end
			default:
			begin
				next_lr.phase  = ST_DEAD;
				next_lr.commit = CM_NONE;
			end
		endcase
		if (!hold_n)
			next_lr = lr; // R2 R5
	end

	always_ff @(posedge sck)
	begin
		lr <= next_lr;
	end

	// ****************************************************************
	// Link side, falling edge: serial output
	// ****************************************************************
	esc_sync #(
		.WIDTH (8)
	) u_sync_link (
		.clk (sck),
		.d   (cr.status),
		.q   (status_sck)
	);

	// Array is only written while select is high, so this read is quiet
	assign rd_byte = mem[lr.addr];

	always_comb
	begin
		next_o = OUT_IDLE;
		if (!fresh)
		begin
			case (lr.phase)
				ST_RDATA:
				begin
					// Busy copy may lag two edges into a frame; first bit is later
					if (!status_sck[SR_BUSY])
					begin
						next_o.bit_q = rd_byte[~lr.cnt[2:0]]; // R3 R13
						next_o.oe_n  = 1'b0;
					end
				end
				ST_SRDATA:
				begin
					next_o.bit_q = status_sck[~lr.cnt[2:0]]; // R18
					next_o.oe_n  = 1'b0;
				end
				default: next_o = OUT_IDLE;
			endcase
		end
	end

	always_ff @(negedge sck or posedge cs_n or negedge hold_n)
	begin
		if (cs_n || !hold_n)
			ro <= OUT_IDLE; // R8 R24
		else
			ro <= next_o; // R23 R5
	end

	assign so      = ro.bit_q;
	assign so_oe_n = ro.oe_n;

	// ****************************************************************
	// System side: commit on select rise, protection, write cycle
	// ****************************************************************
	// Link fields are frozen after select rises, so they are read directly
	esc_sync #(
		.WIDTH (7)
	) u_sync_sys (
		.clk (mclk),
		.d   ({cs_n, wp_n, lr.commit}),
		.q   ({cs_s, wp_s, code_s})
	);

	esc_wtimer #(
		.CYCLES (WRITE_CYCLES)
	) u_timer (
		.clk   (mclk),
		.rst_n (rst_n),
		.start (cr.start),
		.busy  (t_busy),
		.done  (t_done)
	);

	assign cs_rise   = cs_s && !cr.cs_prev;
	assign page_base = lr.addr[ADDR_W-1:PW];

	always_comb
	begin
		next_cr         = cr;
		next_cr.cs_prev = cs_s;
		next_cr.start   = 1'b0;
		next_cr.wr_go   = 1'b0;
		if (t_done)
			next_cr.latch = 1'b0; // R14 R17
		if (cs_rise)
		begin
			case (code_s)
				CM_SET: next_cr.latch = 1'b1; // R9 R16 R20
				CM_CLR: next_cr.latch = 1'b0; // R16 R17 R20
				CM_SWR:
				begin
					if (cr.latch && !t_busy && !(cr.pin_en && !wp_s)) // R22 R25
					begin
						next_cr.pin_en = lr.sdata[SR_PIN_EN];
						next_cr.guard  = lr.sdata[SR_GUARD_HI:SR_GUARD_LO]; // R21
						next_cr.start  = 1'b1;
					end
				end
				CM_AWR:
				begin
					if (cr.latch && !t_busy) // R12 R25
					begin
						next_cr.wr_go = 1'b1;
						next_cr.start = 1'b1;
					end
				end
				default: next_cr.start = 1'b0;
			endcase
		end
		next_cr.status = {cr.pin_en, SR_RSVD, cr.guard, cr.latch, t_busy}; // R19
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			cr <= CTL_RESET; // R17
		else
			cr <= next_cr;
	end

	// Whole page lands in one cycle; the timer only models the write cycle time
	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < PAGE_BYTES; i++)
		begin
			if (cr.wr_go && lr.mask[i] && !guarded({page_base, PW'(i)}, cr.guard)) // R26 R11
				mem[{page_base, PW'(i)}] <= lr.pbuf[i];
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_kick;
		cr.start;
	endsequence

	sequence s_latched_write;
		cs_rise && (code_s == CM_AWR) && cr.latch && !t_busy;
	endsequence

	property p_write_starts;
		@(posedge mclk) disable iff (!rst_n)
		s_latched_write |=> cr.start && cr.wr_go ##1 t_busy;
	endproperty

	a_write_starts: assert property (p_write_starts) // R12
		else $error("complete latched write did not start the cycle");

	a_latch_on_set: assert property (@(posedge mclk) disable iff (!rst_n) // R16
		(cs_rise && code_s == CM_SET) |=> cr.latch)
		else $error("latch set command did not set the latch");

	a_latch_on_clear: assert property (@(posedge mclk) disable iff (!rst_n) // R20
		(cs_rise && code_s == CM_CLR) |=> !cr.latch ##1 !cr.status[SR_LATCH])
		else $error("latch clear command did not clear the latch");

	a_done_clears: assert property (@(posedge mclk) disable iff (!rst_n) // R14
		(t_done && !(cs_rise && code_s == CM_SET)) |=> !cr.latch)
		else $error("latch survived the end of the write cycle");

	a_no_latch_write: assert property (@(posedge mclk) disable iff (!rst_n) // R25
		(cs_rise && !cr.latch) |=> !cr.start && !cr.wr_go)
		else $error("write started with the latch cleared");

	a_pin_locks: assert property (@(posedge mclk) disable iff (!rst_n) // R22
		(cs_rise && code_s == CM_SWR && cr.pin_en && !wp_s) |=> $stable(cr.guard) && $stable(cr.pin_en))
		else $error("status written while pin protection was active");

	a_busy_span: assert property (@(posedge mclk) disable iff (!rst_n) // R19
		s_kick |=> t_busy [*8] ##1 cr.status[SR_BUSY])
		else $error("busy flag did not cover the write cycle");

	a_start_cause: assert property (@(posedge mclk) disable iff (!rst_n) // R12
		s_kick |-> $past(cs_rise) && ($past(code_s) == CM_AWR || $past(code_s) == CM_SWR))
		else $error("write cycle started without a complete command");

	a_read_wrap: assert property (@(posedge sck) disable iff (cs_n) // R7
		(!fresh && hold_n && lr.phase == ST_RDATA && lr.cnt == BYTE_LAST && lr.addr == ADDR_LAST)
		|=> lr.addr == ADDR_ZERO)
		else $error("read address did not roll over to zero");

	a_pause_freezes: assert property (@(posedge sck) disable iff (cs_n) // R5
		(!hold_n && !fresh) |=> $stable(lr.cnt) && $stable(lr.phase))
		else $error("link state moved while paused");
endmodule // esc_core
`default_nettype wire

//--- test/esc_host.sv
// Host model: frames on the serial link, samples serial output
`timescale 1ns/1ps
`default_nettype none
module esc_host (
	input  wire logic mclk,    // System clock, paces frames
	input  wire logic so,      // Serial data out
	input  wire logic so_oe_n, // Low while device drives so
	output logic      sck,     // Serial clock, still outside frames
	output logic      cs_n,    // Chip select, active low
	output logic      si,      // Serial data in
	output logic      hold_n   // Pause, active low
);
	logic [7:0] txb [0:39];
	logic [7:0] rxb [0:39];
	logic       oe_seen;
	logic       hold_ok;
	int         j;

	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		hold_n = 1'b1;
		oe_seen = 1'b0;
		hold_ok = 1'b0;
		for (j = 0; j < 40; j++)
			txb[j] = 8'h00;
	end

	// ****************************************************************
	// One select period; hat picks a bit to pause before, -1 none
	// ****************************************************************
	task automatic frame(input int nb, input int hat);
		int   i;
		logic lb;
		lb = 1'b0;
		oe_seen = 1'b0;
		hold_ok = 1'b0;
		@(posedge mclk);
		#1 cs_n = 1'b0;
		#40;
		for (i = 0; i < nb; i++)
		begin
			if (i == hat)
			begin
				// Pause only while sck is low; pulses must be ignored
				hold_n = 1'b0;
				#20 hold_ok = so_oe_n;
				repeat (2)
				begin
					si = ~si;
					#30 sck = 1'b1;
					#30 sck = 1'b0;
				end
				#20 hold_n = 1'b1;
				#20;
			end
			si = txb[i/8][7-i%8];
			#62.5 sck = 1'b1;
			// Undriven line shows a flipping value, never a stale one
			lb = so_oe_n ? ~lb : so;
			rxb[i/8][7-i%8] = lb;
			if (so_oe_n === 1'b0)
				oe_seen = 1'b1;
			#62.5 sck = 1'b0;
		end
		#62.5 cs_n = 1'b1;
		repeat (6) @(posedge mclk);
	endtask
endmodule // esc_host
`default_nettype wire

//--- test/test_serial_eeprom_command_core.sv
// Self-checking bench for the serial EEPROM command core
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_command_core;
	import esc_pkg::*;
	logic       mclk;
	logic       rst_n;
	logic       wp_n;
	wire logic  sck;
	wire logic  cs_n;
	wire logic  si;
	wire logic  hold_n;
	wire logic  so;
	wire logic  so_oe_n;
	int         error_cnt = 0;
	int         n_compared = 0;
	logic [7:0] s;

	// Short write cycle keeps polling cheap
	esc_core #(.PAGE_BYTES(16), .WRITE_CYCLES(200)) esc_core_i (
		.mclk(mclk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
		.hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n));
	esc_host esc_host_i (
		.mclk(mclk), .so(so), .so_oe_n(so_oe_n), .sck(sck), .cs_n(cs_n),
		.si(si), .hold_n(hold_n));

	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// ****************************************************************
	// Access tasks and compares
	// ****************************************************************
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic stat_rd(output logic [7:0] v);
		esc_host_i.txb[0] = OP_STATUS_READ;
		esc_host_i.frame(16, -1);
		v = esc_host_i.rxb[1];
	endtask

	task automatic cmd(input logic [7:0] op, input int nb);
		esc_host_i.txb[0] = op;
		esc_host_i.frame(nb, -1);
	endtask

	task automatic swr(input logic [7:0] d);
		esc_host_i.txb[1] = d;
		cmd(OP_STATUS_WRITE, 16);
	endtask

	task automatic wr(input logic [15:0] a, input int n, input logic [31:0] d, input int ex, input int hat);
		int k;
		esc_host_i.txb[0] = OP_ARRAY_WRITE;
		{esc_host_i.txb[1], esc_host_i.txb[2]} = a;
		for (k = 0; k < n; k++)
			esc_host_i.txb[3+k] = d[31-8*k -: 8];
		esc_host_i.frame(24 + 8 * n + ex, hat);
	endtask

	task automatic rd(input logic [15:0] a, input int n);
		esc_host_i.txb[0] = OP_ARRAY_READ;
		{esc_host_i.txb[1], esc_host_i.txb[2]} = a;
		esc_host_i.frame(24 + 8 * n, -1);
	endtask

	task automatic wait_idle;
		int         k;
		logic [7:0] v;
		for (k = 0; k < 20; k++)
		begin
			stat_rd(v);
			if (v[SR_BUSY] === 1'b0)
				return;
		end
		error_cnt++;
		$display("[FAIL] %0t write cycle never ended", $time);
		final_report;
	endtask

	task final_report;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial
	begin
		rst_n = 1'b0;
		wp_n = 1'b1;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		stat_rd(s);
		chk8(s, 8'h00);
		wr(16'h0010, 1, 32'ha5000000, 0, -1);
		stat_rd(s);
		chk8(s, 8'h00);
		$display("test reset and locked write done");

		cmd(OP_SET_LATCH, 9);
		stat_rd(s);
		chk8(s, 8'h00);
		cmd(OP_SET_LATCH, 8);
		stat_rd(s);
		chk8(s, 8'h02);
		cmd(OP_CLEAR_LATCH, 8);
		stat_rd(s);
		chk8(s, 8'h00);
		$display("test latch commands done");

		cmd(OP_SET_LATCH, 8);
		wr(16'hfc0e, 4, 32'hc1c2c3c4, 0, -1);
		stat_rd(s);
		chk8(s, 8'h03);
		rd(16'h000e, 1);
		chk1(esc_host_i.oe_seen, 1'b0);
		wait_idle;
		stat_rd(s);
		chk8(s, 8'h00);
		cmd(OP_SET_LATCH, 8);
		wr(16'h03fe, 2, 32'hd1d20000, 0, -1);
		wait_idle;
		rd(16'h03fe, 4);
		chk8(esc_host_i.rxb[3], 8'hd1);
		chk8(esc_host_i.rxb[4], 8'hd2);
		chk8(esc_host_i.rxb[5], 8'hc3);
		chk8(esc_host_i.rxb[6], 8'hc4);
		chk1(so_oe_n, 1'b1);
		rd(16'h000e, 2);
		chk8(esc_host_i.rxb[3], 8'hc1);
		chk8(esc_host_i.rxb[4], 8'hc2);
		$display("test page write and read done");

		cmd(OP_SET_LATCH, 8);
		wr(16'h0005, 1, 32'h77000000, 3, -1);
		stat_rd(s);
		chk8(s, 8'h02);
		swr(8'h84);
		wait_idle;
		stat_rd(s);
		chk8(s, 8'h84);
		wp_n <= 1'b0;
		cmd(OP_SET_LATCH, 8);
		stat_rd(s);
		chk8(s, 8'h86);
		swr(8'h00);
		stat_rd(s);
		chk8(s, 8'h86);
		wr(16'h03ff, 1, 32'h11000000, 0, -1);
		wait_idle;
		stat_rd(s);
		chk8(s, 8'h84);
		rd(16'h03ff, 1);
		chk8(esc_host_i.rxb[3], 8'hd2);
		wp_n <= 1'b1;
		cmd(OP_SET_LATCH, 8);
		swr(8'h00);
		wait_idle;
		stat_rd(s);
		chk8(s, 8'h00);
		$display("test protection done");

		cmd(OP_SET_LATCH, 8);
		wr(16'h0020, 1, 32'h5a000000, 0, 12);
		wait_idle;
		rd(16'h0020, 1);
		chk8(esc_host_i.rxb[3], 8'h5a);
		esc_host_i.txb[0] = OP_STATUS_READ;
		esc_host_i.frame(32, 20);
		chk1(esc_host_i.hold_ok, 1'b1);
		chk8(esc_host_i.rxb[1], 8'h00);
		chk8(esc_host_i.rxb[3], 8'h00);
		$display("test pause done");
		final_report;
	end
endmodule // test_serial_eeprom_command_core
`default_nettype wire
